/* File: include/sync_serial_map.vh */
// register map, field positions and timing constants of the channel
`ifndef SYNC_SERIAL_MAP_VH
`define SYNC_SERIAL_MAP_VH
// register byte offsets
`define A_TXBUF      8'h00
`define A_CTRL       8'h04
`define A_CMD        8'h08
`define A_STATUS     8'h0C
`define A_SKIP       8'h10
`define A_INT_ST     8'h14
`define A_INT_MASK   8'h18
`define A_RXBUF      8'h1C
// control register fields
`define C_IDLE       0
`define C_TERM_RDY   1
`define C_LOCAL_SEL  2
`define CTRL_W       3
`define CTRL_RST     3'h0
// status register fields
`define S_CHR        0
`define S_XMT        1
`define S_RUN        2
`define S_RTS        3
`define S_DSR        4
`define S_CTS        5
`define S_RING       6
`define S_IDLE       7
`define S_RXACT      8
// interrupt bits
`define I_DEMAND     0
`define I_RXCHR      1
`define I_END        2
`define INT_W        3
`define INT_RST      3'h0
// character data
`define CHAR_W       8
`define SYNC_CHAR    8'h16
`define ACC_LSB      3
`define BIT_CNT_W    3
`define BIT_LAST     3'h7
// command code that pulses local timing (octal 6354)
`define LT_CMD       12'hCEC
// time figures
`define CLK_NS       100
`define LT_PULSE_NS  400
`define LT_PULSE_CYC (`LT_PULSE_NS / `CLK_NS)
`define LOC_PER_NS   800
`define LOC_PER_CYC  (`LOC_PER_NS / `CLK_NS)
`define CNT_W        4
// synchronised input bit positions
`define P_XCLK       0
`define P_RCLK       1
`define P_CTS        2
`define P_DSR        3
`define P_RING       4
`define P_RXD        5
`define PIN_N        6
// line level of an idle transmit output
`define MARK         1'b1
`endif

/* File: rtl/pin_sync.v */
// two-flop synchroniser bank for inputs from outside the clock domain
`timescale 1ns/10ps
module pin_sync #(
    parameter N = 1
) (
    // clock and reset
    input  wire         i_mclk,
    input  wire         i_sys_rst,
    // asynchronous inputs and their synchronised copies
    input  wire [N-1:0] i_async,
    output wire [N-1:0] o_sync
);
    genvar g;
    generate
        for (g = 0; g < N; g = g + 1) begin : bit_sync
            reg meta_q;
            reg sync_q;
            // the first stage feeds only the second stage
            always @(posedge i_mclk) begin
                if (i_sys_rst) begin
                    meta_q <= 1'b0;
                    sync_q <= 1'b0;
                end else begin
                    meta_q <= i_async[g];
                    sync_q <= meta_q;
                end
            end
            assign o_sync[g] = sync_q;
        end
    endgenerate
endmodule

/* File: rtl/sync_serial_channel_xmit.v */
// bit-synchronous serial channel: transmit path, receive assembly, bus
//
// Summary of operation
// - load instruction strobes data into buffer
// - buffer moves to shifter only when permitted
// - last bit when stages 3-9, end zero
// - no transmit clocks while clear-to-send off
// - skip register reflects modem ready line
// - idle mode bit set/cleared by software
// - power clear resets all control state
// - serial data taken from shifter stage one
// - command code 6354 emits local timing pulse
// - sync character starts receive assembly
// - pending unmasked flag raises interrupt
// - read data returned on bits 3-11 (the code returns them on bits 3-10)
// - optional internal timing replaces modem clock
// - transfer sets demand, load sets loaded
// - only sync character starts transmission
// - no character in time ends message
// - idle mode resends last character
//
// Implementation choices: the register offsets and the Wishbone register port.
`timescale 1ns/10ps
`include "sync_serial_map.vh"
module sync_serial_channel_xmit (
    // clock and reset
    input  wire        i_mclk,
    input  wire        i_sys_rst,
    // wishbone slave
    input  wire        i_wb_cyc,
    input  wire        i_wb_stb,
    input  wire        i_wb_we,
    input  wire [7:0]  i_wb_adr,
    input  wire [3:0]  i_wb_sel,
    input  wire [31:0] i_wb_dat,
    output reg  [31:0] o_wb_dat,
    output reg         o_wb_ack,
    // modem side inputs
    input  wire        i_xmit_clk,
    input  wire        i_rcv_clk,
    input  wire        i_clear_to_send,
    input  wire        i_modem_ready,
    input  wire        i_ring,
    input  wire        i_rxd,
    // modem side outputs
    output reg         o_txd,
    output reg         o_req_to_send,
    output reg         o_term_ready,
    output reg         o_local_timing,
    // interrupt
    output reg         o_irq
);
    // synchronised pins
    wire [`PIN_N-1:0] pin_s;
    reg  [`PIN_N-1:0] pin_q;
    // bus decode
    wire              bus_req;
    wire              wr_stb;
    wire              rd_stb;
    // control state
    reg  [`CTRL_W-1:0] ctrl_q;
    reg  [`INT_W-1:0]  int_st_q;
    reg  [`INT_W-1:0]  int_mask_q;
    reg  [`INT_W-1:0]  int_ev;
    // transmit state
    reg  [`CHAR_W-1:0] tcb_q;
    reg  [`CHAR_W:0]   tb_q;
    reg                tb_end_q;
    reg                char_loaded_flag_q;
    reg                xmit_demand_flag_q;
    reg                xmit_running_ff_q;
    reg                send_req_q;
    // receive state
    reg  [`CHAR_W-1:0] rb_q;
    reg  [`CHAR_W-1:0] rcb_q;
    reg                rx_active_q;
    reg  [`BIT_CNT_W-1:0] rx_cnt_q;
    // timing
    reg  [`CNT_W-1:0]  loc_cnt_q;
    reg  [`CNT_W-1:0]  lt_cnt_q;
    reg                loc_tick_q;
    wire               xmit_tick;
    wire               xmit_clock;
    wire               rcv_tick;
    wire               last_bit;
    wire               xfer_permit;
    wire               load_transmit_instr;
    wire               clear_repeat_instr;
    wire               is_sync;
    wire               init_pulse;
    wire               lt_cmd;
    reg  [31:0]        rd_d;
    wire [31:0]        lt_load;

    // byte-lane aware write of low field; only lane 0 select is checked, though the field is 12 bits
    function lane_ok;
        input [3:0] sel;
        begin
            lane_ok = sel[0];
        end
    endfunction

    // sync character compare, used on both paths
    function sync_match;
        input [`CHAR_W-1:0] c;
        begin
            sync_match = (c == `SYNC_CHAR);
        end
    endfunction

    pin_sync #(
        .N (`PIN_N)
    ) u_pin_sync (
        .i_mclk    (i_mclk),
        .i_sys_rst (i_sys_rst),
        .i_async   ({i_rxd, i_ring, i_modem_ready, i_clear_to_send,
                     i_rcv_clk, i_xmit_clk}),
        .o_sync    (pin_s)
    );

    // delayed copy of synchronised pins for edge detection
    always @(posedge i_mclk) begin
        if (i_sys_rst) begin
            pin_q <= {`PIN_N{1'b0}};
        end else begin
            pin_q <= pin_s;
        end
    end

    // power clear doubles as the internal initialise pulse
    assign init_pulse = i_sys_rst;

    // wishbone decode: one request answered in one cycle
    assign bus_req = i_wb_cyc & i_wb_stb & ~o_wb_ack;
    assign wr_stb  = bus_req & i_wb_we & lane_ok(i_wb_sel);
    assign rd_stb  = bus_req & ~i_wb_we;
    assign load_transmit_instr = wr_stb
                               & (i_wb_adr == `A_TXBUF);
    assign lt_cmd = wr_stb & (i_wb_adr == `A_CMD)
                  & (i_wb_dat[11:0] == `LT_CMD);
    // writing the control word with idle clear acts as the clear
    assign clear_repeat_instr = wr_stb & (i_wb_adr == `A_CTRL)
                              & ~i_wb_dat[`C_IDLE];
    assign is_sync = sync_match(i_wb_dat[`CHAR_W-1:0]);

    // timing source: modem clock edge, or internal divider tick
    assign xmit_tick = ctrl_q[`C_LOCAL_SEL] ? loc_tick_q
                     : (pin_s[`P_XCLK] & ~pin_q[`P_XCLK]);
    assign rcv_tick  = ctrl_q[`C_LOCAL_SEL] ? loc_tick_q
                     : (pin_s[`P_RCLK] & ~pin_q[`P_RCLK]);
    // clear-to-send gates the transmit clock
    assign xmit_clock = xmit_tick & pin_s[`P_CTS]
                      & xmit_running_ff_q;
    assign last_bit = ~(|tb_q[`CHAR_W:2]) & ~tb_end_q;
    // a clear landing on the last bit already stops the repeat
    assign xfer_permit = char_loaded_flag_q
                       | (ctrl_q[`C_IDLE]
                          & ~clear_repeat_instr);
    // pulse length cut to the counter width on purpose
    assign lt_load = `LT_PULSE_CYC;

    // internal timing divider and local timing pulse stretcher
    always @(posedge i_mclk) begin
        if (init_pulse) begin
            loc_cnt_q  <= {`CNT_W{1'b0}};
            loc_tick_q <= 1'b0;
            lt_cnt_q   <= {`CNT_W{1'b0}};
        end else begin
            loc_tick_q <= 1'b0;
            if (loc_cnt_q == `LOC_PER_CYC - 1) begin
                loc_cnt_q  <= {`CNT_W{1'b0}};
                loc_tick_q <= 1'b1;
            end else begin
                loc_cnt_q <= loc_cnt_q + 1'b1;
            end
            if (lt_cmd) begin
                lt_cnt_q <= lt_load[`CNT_W-1:0];
            end else if (lt_cnt_q != {`CNT_W{1'b0}}) begin
                lt_cnt_q <= lt_cnt_q - 1'b1;
            end
        end
    end

    // control and mask registers; idle mode only moves by software
    always @(posedge i_mclk) begin
        if (init_pulse) begin
            ctrl_q     <= `CTRL_RST;
            int_mask_q <= `INT_RST;
        end else if (wr_stb) begin
            if (i_wb_adr == `A_CTRL) begin
                ctrl_q <= i_wb_dat[`CTRL_W-1:0];
            end
            if (i_wb_adr == `A_INT_MASK) begin
                int_mask_q <= i_wb_dat[`INT_W-1:0];
            end
        end
    end

    // transmit buffer, shifter and message control
    always @(posedge i_mclk) begin
        if (init_pulse) begin
            tcb_q              <= {`CHAR_W{1'b0}};
            tb_q               <= {(`CHAR_W+1){1'b0}};
            tb_end_q           <= 1'b0;
            char_loaded_flag_q <= 1'b0;
            xmit_demand_flag_q <= 1'b0;
            xmit_running_ff_q  <= 1'b0;
            send_req_q         <= 1'b0;
        end else begin
            if (xmit_clock) begin
                if (!last_bit) begin
                    // shift toward stage one, end marker follows
                    tb_q     <= {tb_end_q, tb_q[`CHAR_W:1]};
                    tb_end_q <= 1'b0;
                end else if (xfer_permit) begin
                    // new character, or a repeat in idle mode
                    tb_q     <= {1'b0, tcb_q};
                    tb_end_q <= 1'b1;
                    xmit_demand_flag_q <= 1'b1;
                    char_loaded_flag_q <= 1'b0;
                end else begin
                    // program was late: end the message
                    xmit_running_ff_q <= 1'b0;
                    send_req_q        <= 1'b0;
                end
            end
            // a load wins the loaded flag over a same-cycle transfer; demand stays set
            if (load_transmit_instr) begin
                tcb_q              <= i_wb_dat[`CHAR_W-1:0];
                char_loaded_flag_q <= 1'b1;
                if (!(xmit_clock && last_bit && xfer_permit)) begin
                    xmit_demand_flag_q <= 1'b0;
                end
                if (!xmit_running_ff_q) begin
                    xmit_running_ff_q <= is_sync;
                    send_req_q        <= is_sync;
                end
            end
        end
    end

    // receive assembly: hunt for sync, then frame every character
    always @(posedge i_mclk) begin
        if (init_pulse) begin
            rb_q        <= {`CHAR_W{1'b0}};
            rcb_q       <= {`CHAR_W{1'b0}};
            rx_active_q <= 1'b0;
            rx_cnt_q    <= {`BIT_CNT_W{1'b0}};
        end else if (rcv_tick) begin
            rb_q <= {pin_s[`P_RXD], rb_q[`CHAR_W-1:1]};
            if (!rx_active_q) begin
                if (sync_match({pin_s[`P_RXD], rb_q[`CHAR_W-1:1]})) begin
                    rx_active_q <= 1'b1;
                    rx_cnt_q    <= {`BIT_CNT_W{1'b0}};
                end
            end else if (rx_cnt_q == `BIT_LAST) begin
                rcb_q    <= {pin_s[`P_RXD], rb_q[`CHAR_W-1:1]};
                rx_cnt_q <= {`BIT_CNT_W{1'b0}};
            end else begin
                rx_cnt_q <= rx_cnt_q + 1'b1;
            end
        end
    end

    // interrupt events of this cycle
    always @* begin
        int_ev = `INT_RST;
        int_ev[`I_DEMAND] = xmit_clock & last_bit & xfer_permit;
        int_ev[`I_RXCHR]  = rcv_tick & rx_active_q
                          & (rx_cnt_q == `BIT_LAST);
        int_ev[`I_END]    = xmit_clock & last_bit & ~xfer_permit;
    end

    // sticky status: a read clears, a same-cycle event survives
    always @(posedge i_mclk) begin
        if (init_pulse) begin
            int_st_q <= `INT_RST;
        end else if (rd_stb && (i_wb_adr == `A_INT_ST)) begin
            int_st_q <= int_ev;
        end else begin
            int_st_q <= int_st_q | int_ev;
        end
    end

    // read multiplexer; character data ride on bits 3 to 10
    always @* begin
        rd_d = 32'h0;
        case (i_wb_adr)
            `A_TXBUF: begin
                rd_d[`ACC_LSB +: `CHAR_W] = tcb_q;
            end
            `A_CTRL: begin
                rd_d[`CTRL_W-1:0] = ctrl_q;
            end
            `A_STATUS: begin
                rd_d[`S_CHR]   = char_loaded_flag_q;
                rd_d[`S_XMT]   = xmit_demand_flag_q;
                rd_d[`S_RUN]   = xmit_running_ff_q;
                rd_d[`S_RTS]   = o_req_to_send;
                rd_d[`S_DSR]   = pin_s[`P_DSR];
                rd_d[`S_CTS]   = pin_s[`P_CTS];
                rd_d[`S_RING]  = pin_s[`P_RING];
                rd_d[`S_IDLE]  = ctrl_q[`C_IDLE];
                rd_d[`S_RXACT] = rx_active_q;
            end
            `A_SKIP: begin
                rd_d[0] = pin_s[`P_DSR];
            end
            `A_INT_ST: begin
                rd_d[`INT_W-1:0] = int_st_q;
            end
            `A_INT_MASK: begin
                rd_d[`INT_W-1:0] = int_mask_q;
            end
            `A_RXBUF: begin
                rd_d[`ACC_LSB +: `CHAR_W] = rcb_q;
            end
            default: begin
                rd_d = 32'h0; // unmapped reads as zero, still acked
            end
        endcase
    end

    // bus answer and registered outputs
    always @(posedge i_mclk) begin
        if (init_pulse) begin
            o_wb_ack       <= 1'b0;
            o_wb_dat       <= 32'h0;
            o_txd          <= `MARK;
            o_req_to_send  <= 1'b0;
            o_term_ready   <= 1'b0;
            o_local_timing <= 1'b0;
            o_irq          <= 1'b0;
        end else begin
            o_wb_ack <= bus_req;
            if (rd_stb) begin
                o_wb_dat <= rd_d;
            end
            // rts rises with send request on the next timing tick, drops without waiting for one
            if (xmit_tick) begin
                o_req_to_send <= send_req_q;
            end else if (!send_req_q) begin
                o_req_to_send <= 1'b0;
            end
            o_txd <= xmit_running_ff_q ? tb_q[0]
                                       : `MARK;
            o_term_ready   <= ctrl_q[`C_TERM_RDY];
            o_local_timing <= (lt_cnt_q != {`CNT_W{1'b0}});
            o_irq          <= |(int_st_q & int_mask_q);
        end
    end
endmodule

/* File: test/modem_model.sv */
// data set stand-in wired as the loopback fixture
`timescale 1ns/10ps
`include "sync_serial_map.vh"
module modem_model (
    input  wire       i_run,
    input  wire       i_cts_ok,
    input  wire       i_txd,
    input  wire       i_rts,
    input  wire       i_term_ready,
    input  wire       i_local_timing,
    output wire       o_clk,
    output wire       o_cts,
    output wire       o_dsr,
    output wire       o_rxd,
    output reg  [1:0] o_seen
);
    reg       gen = 1'b0;
    reg [7:0] hist = 8'hFF;
    // 800 ns clock, free-running while i_run is set; local pulses also clock
    always #400 gen = i_run ? ~gen : 1'b0;
    assign o_clk = gen | i_local_timing;
    assign o_cts = i_rts & i_cts_ok;
    assign o_dsr = i_term_ready;
    assign o_rxd = i_txd;
    initial o_seen = 2'b00;
    // data settled well before the next edge, lsb arrives first
    always @(posedge o_clk) begin
        hist = {i_txd, hist[7:1]};
        if (hist == `SYNC_CHAR) o_seen[0] = 1'b1;
        if (hist == 8'h5A) o_seen[1] = 1'b1;
    end
endmodule

/* File: test/sync_serial_channel_xmit_asserts.sv */
// port-level assertions for the serial channel
`timescale 1ns/10ps
`include "sync_serial_map.vh"
module sync_serial_asserts (
    input wire        i_mclk,
    input wire        i_sys_rst,
    input wire        i_wb_cyc,
    input wire        i_wb_stb,
    input wire        i_wb_we,
    input wire [7:0]  i_wb_adr,
    input wire [3:0]  i_wb_sel,
    input wire [31:0] i_wb_dat,
    input wire [31:0] o_wb_dat,
    input wire        o_wb_ack,
    input wire        i_clear_to_send,
    input wire        o_txd,
    input wire        o_req_to_send,
    input wire        o_local_timing,
    input wire        o_irq
);
    wire take = i_wb_cyc & i_wb_stb & ~o_wb_ack;
    wire wr0  = take & i_wb_we & i_wb_sel[0];
    wire lt   = wr0 & (i_wb_adr == `A_CMD) & (i_wb_dat[11:0] == `LT_CMD);
    reg  fld_q;
    reg  unm_q;
    // remember which kind of read is being answered
    always @(posedge i_mclk) begin
        fld_q <= take & ~i_wb_we & (i_wb_adr == `A_TXBUF);
        unm_q <= take & ~i_wb_we & (i_wb_adr > `A_RXBUF);
    end
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_sys_rst);
    property p_ack; take |=> o_wb_ack; endproperty
    a_ack: assert property (p_ack) else $error("ack late");
    property p_ack1; o_wb_ack |=> !o_wb_ack; endproperty
    a_ack1: assert property (p_ack1) else $error("ack long");
    property p_mark; $fell(o_req_to_send) |-> ##[0:3] o_txd; endproperty
    a_mark: assert property (p_mark) else $error("no mark");
    property p_lt;
        lt |=> ##1 o_local_timing[*4] ##1 !o_local_timing;
    endproperty
    a_lt: assert property (p_lt) else $error("timing pulse");
    property p_ltc; $rose(o_local_timing) |-> $past(lt, 2); endproperty
    a_ltc: assert property (p_ltc) else $error("stray pulse");
    property p_msk;
        wr0 && i_wb_adr == `A_INT_MASK && i_wb_dat[2:0] == 3'h0 |-> ##2 !o_irq;
    endproperty
    a_msk: assert property (p_msk) else $error("masked irq");
    property p_fld;
        o_wb_ack && fld_q |-> o_wb_dat[31:11] == 21'h0 && o_wb_dat[2:0] == 3'h0;
    endproperty
    a_fld: assert property (p_fld) else $error("read field");
    property p_unm; o_wb_ack && unm_q |-> o_wb_dat == 32'h0; endproperty
    a_unm: assert property (p_unm) else $error("unmapped");
    property p_cts;
        (!i_clear_to_send && o_req_to_send)[*8] |-> $stable(o_txd);
    endproperty
    a_cts: assert property (p_cts) else $error("shift no cts");
endmodule
bind sync_serial_channel_xmit sync_serial_asserts u_sync_serial_asserts (
    .i_mclk, .i_sys_rst, .i_wb_cyc, .i_wb_stb, .i_wb_we, .i_wb_adr, .i_wb_sel,
    .i_wb_dat, .o_wb_dat, .o_wb_ack, .i_clear_to_send, .o_txd, .o_req_to_send,
    .o_local_timing, .o_irq);

/* File: test/tb.sv */
// self-checking bench for the serial channel
`timescale 1ns/10ps
`include "sync_serial_map.vh"
module tb;
    logic        i_mclk = 1'b0;
    logic        i_sys_rst = 1'b1;
    logic        i_wb_cyc = 1'b0;
    logic        i_wb_stb = 1'b0;
    logic        i_wb_we = 1'b0;
    logic [7:0]  i_wb_adr = 8'h00;
    logic [3:0]  i_wb_sel = 4'hF;
    logic [31:0] i_wb_dat = 32'h0;
    logic        run = 1'b0;
    logic        cts_ok = 1'b1;
    logic [31:0] r;
    logic [31:0] acc;
    int          lt_cnt;
    int          miscompares = 0;
    int          comparisons = 0;
    wire [31:0]  o_wb_dat;
    wire         o_wb_ack, o_txd, o_req_to_send, o_term_ready;
    wire         o_local_timing, o_irq, lclk, cts, dsr, rxd;
    wire [1:0]   seen;
    logic [7:0]  regs [5] = '{`A_CTRL, `A_INT_MASK, `A_INT_ST, `A_STATUS, 8'h20};
    sync_serial_channel_xmit u_sync_serial_channel_xmit (
        .i_mclk, .i_sys_rst, .i_wb_cyc, .i_wb_stb, .i_wb_we, .i_wb_adr,
        .i_wb_sel, .i_wb_dat, .o_wb_dat, .o_wb_ack, .i_xmit_clk(lclk),
        .i_rcv_clk(lclk), .i_clear_to_send(cts), .i_modem_ready(dsr),
        .i_ring(dsr), .i_rxd(rxd), .o_txd, .o_req_to_send, .o_term_ready,
        .o_local_timing, .o_irq);
    modem_model u_modem_model (.i_run(run), .i_cts_ok(cts_ok), .i_txd(o_txd),
        .i_rts(o_req_to_send), .i_term_ready(o_term_ready),
        .i_local_timing(o_local_timing), .o_clk(lclk), .o_cts(cts),
        .o_dsr(dsr), .o_rxd(rxd), .o_seen(seen));
    initial begin
        forever #50 i_mclk = ~i_mclk;
    end
    // counts pulse length without racing the bus task
    always @(posedge i_mclk) lt_cnt <= lt_cnt + o_local_timing;
    task automatic wrap_up;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        comparisons++;
        if (s !== e) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic hang(input string nm);
        $display("[ERR] %s expected done seen timeout", nm);
        miscompares++;
        wrap_up;
    endtask
    // one classic cycle; request held until ack is sampled
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge i_mclk);
        i_wb_cyc <= 1'b1;
        i_wb_stb <= 1'b1;
        i_wb_we <= w;
        i_wb_adr <= a;
        i_wb_dat <= d;
        do begin
            @(posedge i_mclk);
            n++;
        end while (o_wb_ack !== 1'b1 && n < 20);
        if (o_wb_ack !== 1'b1) hang("ack");
        r = o_wb_dat;
        i_wb_cyc <= 1'b0;
        i_wb_stb <= 1'b0;
    endtask
    // reads clear status, so every poll result is folded together
    task automatic poll(input logic [7:0] a, input int b);
        acc = 32'h0;
        for (int n = 0; n < 300 && acc[b] !== 1'b1; n++) begin
            wb(1'b0, a, 32'h0);
            acc = acc | r;
        end
        if (acc[b] !== 1'b1) hang("poll");
    endtask
    task automatic t_reset;
        chk("txd", o_txd, 1'b1);
        chk("rts", o_req_to_send, 1'b0);
        foreach (regs[i]) begin
            wb(1'b0, regs[i], 32'h0);
            chk("reset reg", r, 32'h0);
        end
        wb(1'b1, 8'h20, 32'hFF);
        i_wb_sel <= 4'hE;
        wb(1'b1, `A_CTRL, 32'h7);
        i_wb_sel <= 4'hF;
        wb(1'b0, `A_CTRL, 32'h0);
        chk("ctrl sel", r, 32'h0);
        $display("test reset done");
    endtask
    task automatic t_regs;
        int base;
        wb(1'b1, `A_CTRL, 32'h3);
        repeat (6) @(posedge i_mclk);
        chk("term", o_term_ready, 1'b1);
        wb(1'b0, `A_SKIP, 32'h0);
        chk("skip", r, 32'h1);
        wb(1'b0, `A_STATUS, 32'h0);
        chk("status", r & 32'hD0, 32'hD0);
        wb(1'b1, `A_CTRL, 32'h0);
        repeat (6) @(posedge i_mclk);
        wb(1'b0, `A_SKIP, 32'h0);
        chk("skip off", r, 32'h0);
        wb(1'b0, `A_STATUS, 32'h0);
        chk("idle off", r[`S_IDLE], 1'b0);
        base = lt_cnt;
        wb(1'b1, `A_CMD, 32'hCED);
        wb(1'b1, `A_CMD, 32'hCEC);
        repeat (8) @(posedge i_mclk);
        chk("pulse", lt_cnt - base, 32'h4);
        $display("test regs done");
    endtask
    task automatic t_msg;
        cts_ok <= 1'b0;
        run <= 1'b1;
        wb(1'b1, `A_INT_MASK, 32'h7);
        wb(1'b1, `A_TXBUF, 32'h16);
        wb(1'b0, `A_STATUS, 32'h0);
        chk("start", r[2:0], 3'h5);
        repeat (120) @(posedge i_mclk);
        chk("rts up", o_req_to_send, 1'b1);
        wb(1'b0, `A_STATUS, 32'h0);
        chk("no xfer", r[`S_XMT], 1'b0);
        cts_ok <= 1'b1;
        poll(`A_STATUS, `S_XMT);
        chk("xfer", r[`S_CHR], 1'b0);
        chk("irq", o_irq, 1'b1);
        wb(1'b1, `A_TXBUF, 32'h5A);
        wb(1'b0, `A_STATUS, 32'h0);
        chk("load", r[1:0], 2'h1);
        wb(1'b0, `A_TXBUF, 32'h0);
        chk("txbuf", r, 32'h2D0);
        wb(1'b1, `A_INT_MASK, 32'h0);
        wb(1'b1, `A_INT_MASK, 32'h7);
        repeat (2) @(posedge i_mclk);
        chk("irq back", o_irq, 1'b1);
        poll(`A_INT_ST, `I_END);
        repeat (20) @(posedge i_mclk);
        chk("rts down", o_req_to_send, 1'b0);
        chk("mark", o_txd, 1'b1);
        chk("wire", seen, 2'h3);
        wb(1'b0, `A_STATUS, 32'h0);
        chk("ended", r[`S_RUN], 1'b0);
        chk("rx", r[`S_RXACT], 1'b1);
        $display("test message done");
    endtask
    task automatic t_idle;
        wb(1'b1, `A_CTRL, 32'h1);
        wb(1'b1, `A_TXBUF, 32'h16);
        poll(`A_STATUS, `S_XMT);
        repeat (400) @(posedge i_mclk);
        wb(1'b0, `A_STATUS, 32'h0);
        chk("resend", r[`S_RUN], 1'b1);
        wb(1'b1, `A_CTRL, 32'h0);
        poll(`A_INT_ST, `I_END);
        repeat (20) @(posedge i_mclk);
        chk("idle end", o_req_to_send, 1'b0);
        wb(1'b1, `A_TXBUF, 32'h41);
        wb(1'b0, `A_STATUS, 32'h0);
        chk("not sync run", r[`S_RUN], 1'b0);
        repeat (100) @(posedge i_mclk);
        chk("not sync", o_req_to_send, 1'b0);
        run <= 1'b0;
        $display("test idle done");
    endtask
    // modem clock stopped: only the internal divider can shift
    task automatic t_local;
        wb(1'b1, `A_CTRL, 32'h4);
        wb(1'b1, `A_TXBUF, 32'h16);
        poll(`A_STATUS, `S_XMT);
        chk("local xfer", r[`S_CHR], 1'b0);
        poll(`A_INT_ST, `I_END);
        wb(1'b0, `A_STATUS, 32'h0);
        chk("local end", r[`S_RUN], 1'b0);
        wb(1'b1, `A_CTRL, 32'h0);
        $display("test local done");
    endtask
    initial begin
        repeat (4) @(posedge i_mclk);
        i_sys_rst <= 1'b0;
        repeat (3) @(posedge i_mclk);
        t_reset;
        t_regs;
        t_msg;
        t_idle;
        t_local;
        wrap_up;
    end
endmodule
